//--- hw/rwi_core.sv
// Reset sequencer, write-once options and CPU interrupt entry and return
`timescale 1ns/1ps
`default_nettype none
`include "rwi_defines.svh"
module rwi_core
   import rwi_pkg::*;
#(
   parameter int WDOG_LONG_CYC  = `RWI_WDOG_LONG,
   parameter int WDOG_SHORT_CYC = `RWI_WDOG_SHORT
) (
   input  wire logic                 clk_i,
   input  wire logic                 reset_i,
   input  wire logic                 lvd_i,
   input  wire logic                 illegal_op_i,
   input  wire logic                 clock_loss_i,
   input  wire logic                 debug_reset_i,
   input  wire logic                 reset_pin_i,
   output logic                      reset_pin_o,
   output logic                      reset_pin_oe_n_o,
   input  wire logic                 opt_write_i,
   input  wire logic                 opt_enable_i,
   input  wire logic                 opt_long_i,
   input  wire logic                 cause_write_i,
   input  wire logic                 debug_active_i,
   input  wire logic [7:0]           event_i,
   input  wire logic [7:0]           flag_clr_i,
   input  wire logic [7:0]           irq_en_i,
   input  wire logic                 instr_done_i,
   input  wire logic                 rti_i,
   input  wire rwi_cpu_regs_t        cpu_regs_i,
   input  wire logic [7:0]           mem_rdata_i,
   output rwi_bus_t                  bus_o,
   output rwi_cpu_regs_t             cpu_regs_o,
   output logic                      regs_load_o,
   output logic [23:0]               queue_o,
   output logic                      queue_valid_o,
   output logic                      cpu_hold_o,
   output logic                      periph_reset_o,
   output logic                      clk_self_mode_o,
   output logic [7:0]                reset_cause_o,
   output logic [7:0]                flags_o,
   output logic                      wdog_enable_o,
   output logic                      wdog_long_o
);
   rwi_core_st_t r_reg;
   rwi_core_st_t r_next;
   logic         wdog_to;
   logic [7:0]   hw_cause;
   logic         rst_any;
   logic [7:0]   irq;

   localparam rwi_core_st_t RESET_ST = '{
      state: RWI_DRIVE, cnt: 8'h00, regs: '0, bus: '0, vbase: 16'h0000,
      cause: 8'h00, acc: `RWI_CAUSE_POR, opt_en: 1'b1, opt_long: `RWI_OPT_LONG_RST,
      opt_locked: 1'b0, flags: 8'h00, src: 3'h0, regs_load: 1'b0, pin_drive: 1'b1,
      in_reset: 1'b1, pin_s1: 1'b1, pin_s2: 1'b1, qbytes: 24'h000000, qvalid: 1'b0};

   // Lowest index wins
   function automatic logic [2:0] rwi_pick(input logic [7:0] req);
      logic [2:0] p;
      p = 3'h0;
      for (int i = `RWI_NSRC - 1; i >= 0; i--) begin
         if (req[i]) begin
            p = 3'(i);
         end
      end
      return p;
   endfunction

   // Vectors step down two bytes per source
   function automatic logic [15:0] rwi_vec_addr(input logic [2:0] src);
      return `RWI_VEC_TOP - {12'h000, src, 1'b0};
   endfunction

   rwi_watchdog #(
      .LONG_CYC  (18'(WDOG_LONG_CYC - 1)),
      .SHORT_CYC (18'(WDOG_SHORT_CYC - 1))
   ) u_wdog (
      .clk_i     (clk_i),
      .reset_i   (reset_i),
      .enable_i  (r_reg.opt_en && !r_reg.in_reset),
      .long_i    (r_reg.opt_long),
      .clear_i   (cause_write_i || r_reg.in_reset),
      .suspend_i (debug_active_i),
      .timeout_o (wdog_to)
   );

   always_comb begin
      r_next = r_reg;
      r_next.regs_load = 1'b0;
      r_next.qvalid = 1'b0;
      r_next.bus.rd = 1'b0;
      r_next.bus.wr = 1'b0;
      r_next.cnt = r_reg.cnt + 8'h01;
      r_next.pin_s1 = reset_pin_i;
      r_next.pin_s2 = r_reg.pin_s1;
      // Set wins over clear
      r_next.flags = (r_reg.flags & ~flag_clr_i) | event_i;
      irq = r_reg.flags & irq_en_i;
      hw_cause = (lvd_i ? `RWI_CAUSE_LVD : 8'h00) | (illegal_op_i ? `RWI_CAUSE_ILOP : 8'h00)
               | (clock_loss_i ? `RWI_CAUSE_CLK : 8'h00) | (wdog_to ? `RWI_CAUSE_WDOG : 8'h00);
      rst_any = (|hw_cause) || debug_reset_i || (!r_reg.in_reset && !r_reg.pin_s2);
      if (opt_write_i && !r_reg.opt_locked) begin
         r_next.opt_en = opt_enable_i;
         r_next.opt_long = opt_long_i;
         r_next.opt_locked = 1'b1;
      end
      case (r_reg.state)
         RWI_DRIVE: begin
            r_next.acc = r_reg.acc | hw_cause;
            if (r_reg.cnt == `RWI_DRIVE_CYC - 8'h01) begin
               r_next.pin_drive = 1'b0;
               r_next.state = RWI_WAIT;
               r_next.cnt = 8'h00;
            end
         end
         RWI_WAIT: begin
            r_next.acc = r_reg.acc | hw_cause;
            if (r_reg.cnt == `RWI_SAMPLE_CYC - 8'h01) begin
               r_next.cause = r_reg.acc | hw_cause | (r_reg.pin_s2 ? 8'h00 : `RWI_CAUSE_PIN);
               r_next.acc = 8'h00;
               r_next.vbase = `RWI_RST_VEC;
               r_next.state = RWI_VEC;
               r_next.cnt = 8'h00;
            end
         end
         RWI_VEC: begin
            r_next.bus.rd = r_reg.cnt < 8'h02;
            r_next.bus.addr = r_reg.vbase + {8'h00, r_reg.cnt};
            if (r_reg.cnt == 8'h02) begin
               r_next.regs.pc[15:8] = mem_rdata_i;
            end
            if (r_reg.cnt == 8'h03) begin
               r_next.regs.pc[7:0] = mem_rdata_i;
               r_next.cnt = 8'h00;
               if (r_reg.in_reset) begin
                  r_next.regs.sp = `RWI_SP_INIT;
                  r_next.regs.condition_code_register[`RWI_CCR_I] = 1'b1;
                  r_next.in_reset = 1'b0;
                  r_next.regs_load = 1'b1;
                  r_next.state = RWI_RUN;
               end else begin
                  r_next.state = RWI_FILL;
               end
            end
         end
         RWI_RUN: begin
            r_next.cnt = 8'h00;
            if (instr_done_i) begin
               if (rti_i) begin
                  r_next.regs = cpu_regs_i;
                  r_next.state = RWI_UNSTACK;
               end else if ((|irq) && !cpu_regs_i.condition_code_register[`RWI_CCR_I]) begin
                  r_next.regs = cpu_regs_i;
                  r_next.src = rwi_pick(irq);
                  r_next.state = RWI_STACK;
               end
            end
         end
         RWI_STACK: begin
            r_next.bus.wr = 1'b1;
            r_next.bus.addr = r_reg.regs.sp - {8'h00, r_reg.cnt};
            case (r_reg.cnt)
               8'h00: r_next.bus.wdata = r_reg.regs.pc[7:0];
               8'h01: r_next.bus.wdata = r_reg.regs.pc[15:8];
               8'h02: r_next.bus.wdata = r_reg.regs.x;
               8'h03: r_next.bus.wdata = r_reg.regs.a;
               default: r_next.bus.wdata = r_reg.regs.condition_code_register;
            endcase
            if (r_reg.cnt == 8'h04) begin
               r_next.regs.sp = r_reg.regs.sp - 16'h0005;
               r_next.regs.condition_code_register[`RWI_CCR_I] = 1'b1;
               r_next.vbase = rwi_vec_addr(r_reg.src);
               r_next.state = RWI_VEC;
               r_next.cnt = 8'h00;
            end
         end
         RWI_UNSTACK: begin
            r_next.bus.rd = r_reg.cnt < 8'h05;
            r_next.bus.addr = r_reg.regs.sp + 16'h0001 + {8'h00, r_reg.cnt};
            case (r_reg.cnt)
               8'h02: r_next.regs.condition_code_register = mem_rdata_i;
               8'h03: r_next.regs.a = mem_rdata_i;
               8'h04: r_next.regs.x = mem_rdata_i;
               8'h05: r_next.regs.pc[15:8] = mem_rdata_i;
               8'h06: r_next.regs.pc[7:0] = mem_rdata_i;
               default: ;
            endcase
            if (r_reg.cnt == 8'h06) begin
               r_next.regs.sp = r_reg.regs.sp + 16'h0005;
               r_next.state = RWI_FILL;
               r_next.cnt = 8'h00;
            end
         end
         RWI_FILL: begin
            r_next.bus.rd = r_reg.cnt < 8'h03;
            r_next.bus.addr = r_reg.regs.pc + {8'h00, r_reg.cnt};
            if (r_reg.cnt >= 8'h02) begin
               r_next.qbytes = {r_reg.qbytes[15:0], mem_rdata_i};
            end
            if (r_reg.cnt == 8'h04) begin
               r_next.qvalid = 1'b1;
               r_next.regs_load = 1'b1;
               r_next.state = RWI_RUN;
               r_next.cnt = 8'h00;
            end
         end
         default: begin
            r_next.state = RWI_DRIVE;
            r_next.cnt = 8'h00;
         end
      endcase
      if (rst_any && r_reg.state != RWI_DRIVE) begin
         r_next.state = RWI_DRIVE;
         r_next.cnt = 8'h00;
         r_next.acc = r_reg.acc | hw_cause | (!r_reg.in_reset && !r_reg.pin_s2 ? `RWI_CAUSE_PIN : 8'h00);
         r_next.pin_drive = 1'b1;
         r_next.in_reset = 1'b1;
         r_next.opt_en = 1'b1;
         r_next.opt_long = `RWI_OPT_LONG_RST;
         r_next.opt_locked = 1'b0;
         r_next.flags = 8'h00;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         r_reg <= RESET_ST;
      end else begin
         r_reg <= r_next;
      end
   end

   assign reset_pin_o      = 1'b0;
   assign reset_pin_oe_n_o = !r_reg.pin_drive;
   assign bus_o            = r_reg.bus;
   assign cpu_regs_o       = r_reg.regs;
   assign regs_load_o      = r_reg.regs_load;
   assign queue_o          = r_reg.qbytes;
   assign queue_valid_o    = r_reg.qvalid;
   assign cpu_hold_o       = r_reg.state != RWI_RUN;
   assign periph_reset_o   = r_reg.in_reset;
   assign clk_self_mode_o  = r_reg.in_reset;
   assign reset_cause_o    = r_reg.cause;
   assign flags_o          = r_reg.flags;
   assign wdog_enable_o    = r_reg.opt_en;
   assign wdog_long_o      = r_reg.opt_long;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   pin_drive_len_a: assert property (r_reg.state == RWI_DRIVE && r_reg.cnt == 8'd33 && !rst_any
      |=> reset_pin_oe_n_o && r_reg.state == RWI_WAIT)
      else $error("reset pin not released after 34 cycles");
   pin_sample_wait_a: assert property (r_reg.state == RWI_WAIT && r_reg.cnt == 8'd37 && !rst_any
      |=> r_reg.state == RWI_VEC && r_reg.vbase == `RWI_RST_VEC)
      else $error("pin sample not after 38 cycles");
   reset_vector_a: assert property (r_reg.state == RWI_VEC && r_reg.in_reset && r_reg.cnt == 8'h00 && !rst_any
      |=> bus_o.rd && bus_o.addr == `RWI_RST_VEC ##1 bus_o.rd && bus_o.addr == 16'hffff)
      else $error("reset vector fetch wrong");
   reset_init_a: assert property ($fell(r_reg.in_reset)
      |-> cpu_regs_o.sp == `RWI_SP_INIT && cpu_regs_o.condition_code_register[`RWI_CCR_I] && regs_load_o)
      else $error("reset stack pointer or mask wrong");
   reset_outputs_a: assert property (!reset_pin_oe_n_o |-> periph_reset_o && clk_self_mode_o)
      else $error("peripherals live during reset drive");
   option_lock_a: assert property (r_reg.opt_locked && !rst_any && r_reg.state != RWI_DRIVE
      |=> r_reg.opt_en == $past(r_reg.opt_en) && r_reg.opt_long == $past(r_reg.opt_long))
      else $error("locked option register changed");
   wdog_reset_a: assert property (wdog_to |=> r_reg.state == RWI_DRIVE && !reset_pin_oe_n_o)
      else $error("watchdog timeout did not reset");
   stack_order_a: assert property (r_reg.state == RWI_STACK && r_reg.cnt == 8'h00 && !rst_any
      |=> bus_o.wr && bus_o.wdata == $past(r_reg.regs.pc[7:0])
      ##1 bus_o.wr && bus_o.wdata == $past(r_reg.regs.pc[15:8], 2))
      else $error("stack order wrong");
   stack_end_a: assert property (r_reg.state == RWI_STACK && r_reg.cnt == 8'h04 && !rst_any
      |=> cpu_regs_o.sp == $past(cpu_regs_o.sp) - 16'h0005 && cpu_regs_o.condition_code_register[`RWI_CCR_I])
      else $error("stack pointer or mask wrong after stacking");
   mask_blocks_a: assert property (r_reg.state == RWI_RUN && instr_done_i && !rti_i
      && cpu_regs_i.condition_code_register[`RWI_CCR_I] && !rst_any |=> r_reg.state == RWI_RUN)
      else $error("interrupt taken while masked");
   no_take_mid_a: assert property (r_reg.state == RWI_RUN && !instr_done_i && !rst_any
      |=> r_reg.state == RWI_RUN)
      else $error("entry started inside an instruction");
   flag_set_a: assert property ((|event_i) && !rst_any |=> (flags_o & $past(event_i)) == $past(event_i))
      else $error("event flag not set");

   reset_done_c: cover property ($fell(r_reg.in_reset));
   irq_entry_c: cover property (r_reg.state == RWI_STACK ##[1:20] queue_valid_o);
   rti_done_c: cover property (r_reg.state == RWI_UNSTACK ##[1:20] queue_valid_o);
endmodule
`default_nettype wire

//--- hw/rwi_defines.svh
// Constants for the reset, watchdog and interrupt entry block
`ifndef RWI_DEFINES_SVH
`define RWI_DEFINES_SVH
`define RWI_RST_VEC      16'hfffe
`define RWI_SP_INIT      16'h00ff
`define RWI_VEC_TOP      16'hfffc
`define RWI_CCR_I        3
`define RWI_DRIVE_CYC    8'd34
`define RWI_SAMPLE_CYC   8'd38
`define RWI_WDOG_LONG    262144
`define RWI_WDOG_SHORT   8192
`define RWI_NSRC         8
`define RWI_CAUSE_POR    8'h80
`define RWI_CAUSE_PIN    8'h40
`define RWI_CAUSE_WDOG   8'h20
`define RWI_CAUSE_ILOP   8'h10
`define RWI_CAUSE_CLK    8'h04
`define RWI_CAUSE_LVD    8'h02
`define RWI_OPT_LONG_RST 1'b1
`endif

//--- hw/rwi_pkg.sv
// Types for the reset, watchdog and interrupt entry block
package rwi_pkg;
   typedef enum logic [3:0] {
      RWI_DRIVE   = 4'h0,
      RWI_WAIT    = 4'h1,
      RWI_VEC     = 4'h3,
      RWI_RUN     = 4'h2,
      RWI_STACK   = 4'h6,
      RWI_FILL    = 4'h7,
      RWI_UNSTACK = 4'h5
   } rwi_state_t;

   typedef struct packed {
      logic [15:0] pc;
      logic [15:0] sp;
      logic [7:0]  x;
      logic [7:0]  a;
      logic [7:0]  condition_code_register;
   } rwi_cpu_regs_t;

   typedef struct packed {
      logic [15:0] addr;
      logic        rd;
      logic        wr;
      logic [7:0]  wdata;
   } rwi_bus_t;

   typedef struct packed {
      logic [17:0] cnt;
      logic        timeout;
   } rwi_wdog_st_t;

   typedef struct packed {
      rwi_state_t    state;
      logic [7:0]    cnt;
      rwi_cpu_regs_t regs;
      rwi_bus_t      bus;
      logic [15:0]   vbase;
      logic [7:0]    cause;
      logic [7:0]    acc;
      logic          opt_en;
      logic          opt_long;
      logic          opt_locked;
      logic [7:0]    flags;
      logic [2:0]    src;
      logic          regs_load;
      logic          pin_drive;
      logic          in_reset;
      logic          pin_s1;
      logic          pin_s2;
      logic [23:0]   qbytes;
      logic          qvalid;
   } rwi_core_st_t;
endpackage

//--- hw/rwi_watchdog.sv
// Watchdog counter with service clear, suspend and two periods
`timescale 1ns/1ps
`default_nettype none
`include "rwi_defines.svh"
module rwi_watchdog
   import rwi_pkg::*;
#(
   parameter logic [17:0] LONG_CYC  = 18'(`RWI_WDOG_LONG - 1),
   parameter logic [17:0] SHORT_CYC = 18'(`RWI_WDOG_SHORT - 1)
) (
   input  wire logic clk_i,
   input  wire logic reset_i,
   input  wire logic enable_i,
   input  wire logic long_i,
   input  wire logic clear_i,
   input  wire logic suspend_i,
   output logic      timeout_o
);
   rwi_wdog_st_t r_reg;
   rwi_wdog_st_t r_next;
   logic [17:0]  limit;

   always_comb begin
      limit = long_i ? LONG_CYC : SHORT_CYC;
      r_next = r_reg;
      r_next.timeout = 1'b0;
      if (clear_i || !enable_i) begin
         r_next.cnt = 18'h00000;
      end else if (!suspend_i) begin
         if (r_reg.cnt >= limit) begin
            r_next.timeout = 1'b1;
            r_next.cnt = 18'h00000;
         end else begin
            r_next.cnt = r_reg.cnt + 18'h00001;
         end
      end
   end

   always_ff @(posedge clk_i or posedge reset_i) begin
      if (reset_i) begin
         r_reg <= '0;
      end else begin
         r_reg <= r_next;
      end
   end

   assign timeout_o = r_reg.timeout;

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (reset_i);

   service_clear_a: assert property (clear_i |=> r_reg.cnt == 18'h00000 && !timeout_o)
      else $error("watchdog not cleared by service");
   debug_suspend_a: assert property (enable_i && suspend_i && !clear_i |=> $stable(r_reg.cnt))
      else $error("watchdog counted while suspended");
   count_step_a: assert property (enable_i && !suspend_i && !clear_i && r_reg.cnt < limit
      |=> r_reg.cnt == $past(r_reg.cnt) + 18'h00001)
      else $error("watchdog did not count one per cycle");
endmodule
`default_nettype wire

//--- sim/reset_watchdog_interrupt_entry_tb_top.sv
// Testbench for the reset, watchdog and interrupt entry core
`timescale 1ns/1ps
`default_nettype none
`include "rwi_defines.svh"
module reset_watchdog_interrupt_entry_tb_top;
   import rwi_pkg::*;
   logic          clk_i = 0, reset_i = 1, opt_write_i = 0, opt_enable_i = 0, opt_long_i = 0;
   logic          cause_write_i = 0, debug_active_i = 0, instr_done_i = 0, rti_i = 0;
   logic [4:0]    src_req = 0;
   logic [7:0]    event_i = 0, flag_clr_i = 0, irq_en_i = 0, mem_rdata_i;
   rwi_cpu_regs_t cpu_regs_i = '0, cpu_regs_o;
   rwi_bus_t      bus_o;
   logic          reset_pin_i, reset_pin_o, reset_pin_oe_n_o, regs_load_o, queue_valid_o, cpu_hold_o;
   logic          periph_reset_o, clk_self_mode_o, wdog_enable_o, wdog_long_o;
   logic [23:0]   queue_o;
   logic [7:0]    reset_cause_o, flags_o;
   int            error_cnt = 0, n_compared = 0, n;
   logic [7:0]    exp_cause [5] = '{`RWI_CAUSE_LVD, `RWI_CAUSE_ILOP, `RWI_CAUSE_CLK, 8'h00, `RWI_CAUSE_PIN};

   // Pin wire: pulled up unless the core or the bench pulls it low
   assign reset_pin_i = !reset_pin_oe_n_o ? reset_pin_o : !src_req[4];

   always #50 clk_i = ~clk_i;

   rwi_core #(.WDOG_LONG_CYC(64), .WDOG_SHORT_CYC(16)) dut (
      .clk_i(clk_i), .reset_i(reset_i), .lvd_i(src_req[0]), .illegal_op_i(src_req[1]),
      .clock_loss_i(src_req[2]), .debug_reset_i(src_req[3]), .reset_pin_i(reset_pin_i),
      .reset_pin_o(reset_pin_o), .reset_pin_oe_n_o(reset_pin_oe_n_o), .opt_write_i(opt_write_i),
      .opt_enable_i(opt_enable_i), .opt_long_i(opt_long_i), .cause_write_i(cause_write_i),
      .debug_active_i(debug_active_i), .event_i(event_i), .flag_clr_i(flag_clr_i), .irq_en_i(irq_en_i),
      .instr_done_i(instr_done_i), .rti_i(rti_i), .cpu_regs_i(cpu_regs_i), .mem_rdata_i(mem_rdata_i),
      .bus_o(bus_o), .cpu_regs_o(cpu_regs_o), .regs_load_o(regs_load_o), .queue_o(queue_o),
      .queue_valid_o(queue_valid_o), .cpu_hold_o(cpu_hold_o), .periph_reset_o(periph_reset_o),
      .clk_self_mode_o(clk_self_mode_o), .reset_cause_o(reset_cause_o), .flags_o(flags_o),
      .wdog_enable_o(wdog_enable_o), .wdog_long_o(wdog_long_o));

   rwi_mem_model u_mem (.clk_i(clk_i), .bus_i(bus_o), .rdata_o(mem_rdata_i));

   task automatic tick();
      @(posedge clk_i);
      #1;
   endtask

   task automatic chk(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wait_load();
      int k;
      k = 0;
      do begin
         tick();
         k++;
      end while (regs_load_o !== 1'b1 && k < 300);
      chk(regs_load_o, 1);
   endtask

   task automatic step(input logic return_from_interrupt, input rwi_cpu_regs_t r);
      cpu_regs_i = r;
      rti_i = return_from_interrupt;
      instr_done_i = 1;
      tick();
      instr_done_i = 0;
      rti_i = 0;
   endtask

   task automatic opt(input logic en, input logic lng);
      opt_enable_i = en;
      opt_long_i = lng;
      opt_write_i = 1;
      tick();
      opt_write_i = 0;
   endtask

   task automatic service();
      cause_write_i = 1;
      tick();
      cause_write_i = 0;
   endtask

   task automatic stop_test();
      $display("errors %0d compared %0d", error_cnt, n_compared);
      if (error_cnt == 0 && n_compared > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   initial begin
      #(100 * 20000);
      error_cnt++;
      stop_test();
   end

   initial begin
      repeat (12) @(posedge clk_i);
      #1;
      chk({reset_pin_oe_n_o, periph_reset_o, clk_self_mode_o, cpu_hold_o}, 4'h7);
      reset_i = 0;
      n = 1;
      tick();
      while (reset_pin_oe_n_o === 1'b0 && n < 100) begin
         n++;
         tick();
      end
      chk(n, 34);
      n = 0;
      while (reset_cause_o === 8'h00 && n < 100) begin
         n++;
         tick();
      end
      chk(n, 38);
      wait_load();
      chk(cpu_regs_o.pc, 16'h1234);
      chk(cpu_regs_o.sp, `RWI_SP_INIT);
      chk(cpu_regs_o.condition_code_register[3], 1);
      chk(reset_cause_o, `RWI_CAUSE_POR);
      chk({wdog_enable_o, wdog_long_o, periph_reset_o}, 3'b110);
      opt(1, 0);
      tick();
      opt(1, 1);
      chk(wdog_long_o, 0);
      repeat (6) begin
         repeat (10) tick();
         service();
      end
      debug_active_i = 1;
      repeat (40) tick();
      debug_active_i = 0;
      service();
      chk({cpu_hold_o, reset_cause_o}, 9'h080);
      n = 0;
      while (cpu_hold_o === 1'b0 && n < 50) begin
         n++;
         tick();
      end
      chk(n >= 15 && n <= 18, 1);
      wait_load();
      chk(reset_cause_o, `RWI_CAUSE_WDOG);
      // Two sources pending; the lower index must win
      service();
      event_i = 8'h24;
      tick();
      event_i = 0;
      irq_en_i = 8'hff;
      chk(flags_o, 8'h24);
      step(0, {16'h2000, 16'h00f0, 8'h11, 8'h22, 8'h08});
      tick();
      chk(cpu_hold_o, 0);
      step(0, {16'h2000, 16'h00f0, 8'h11, 8'h22, 8'h00});
      tick();
      chk(cpu_hold_o, 1);
      wait_load();
      chk({cpu_regs_o.pc, cpu_regs_o.sp[7:0]}, 24'h3000eb);
      chk({cpu_regs_o.condition_code_register[3], queue_valid_o}, 2'b11);
      chk(queue_o, 24'ha1a2a3);
      chk({u_mem.mem[16'h00f0], u_mem.mem[16'h00ef], u_mem.mem[16'h00ee]}, 24'h002011);
      chk({u_mem.mem[16'h00ed], u_mem.mem[16'h00ec]}, 16'h2200);
      flag_clr_i = 8'hff;
      step(1, {16'h3010, 16'h00eb, 8'h00, 8'h00, 8'h08});
      flag_clr_i = 0;
      wait_load();
      chk({cpu_regs_o.pc, cpu_regs_o.sp[7:0]}, 24'h2000f0);
      chk({cpu_regs_o.x, cpu_regs_o.a, cpu_regs_o.condition_code_register}, 24'h112200);
      chk(queue_o, 24'hb1b2b3);
      chk(flags_o, 8'h00);
      for (int i = 0; i < 5; i++) begin
         service();
         src_req = 5'h1 << i;
         repeat (3) tick();
         src_req = 0;
         chk({periph_reset_o, clk_self_mode_o, cpu_hold_o}, 3'b111);
         wait_load();
         chk(reset_cause_o, exp_cause[i]);
      end
      opt(0, 1);
      repeat (100) tick();
      chk({cpu_hold_o, wdog_enable_o}, 2'b00);
      stop_test();
   end
endmodule
`default_nettype wire

//--- sim/rwi_mem_model.sv
// Memory partner that answers the core's bus reads one cycle late
`timescale 1ns/1ps
`default_nettype none
module rwi_mem_model
   import rwi_pkg::*;
(
   input  wire logic     clk_i,
   input  wire rwi_bus_t bus_i,
   output logic [7:0]    rdata_o
);
   logic [7:0] mem [0:65535];
   initial begin
      rdata_o = 8'h5a;
      mem[16'hfffe] = 8'h12;
      mem[16'hffff] = 8'h34;
      mem[16'hfffc] = 8'h40;
      mem[16'hfffd] = 8'h00;
      mem[16'hfff8] = 8'h30;
      mem[16'hfff9] = 8'h00;
      for (int i = 0; i < 3; i++) begin
         mem[16'h3000 + i] = 8'ha1 + 8'(i);
         mem[16'h2000 + i] = 8'hb1 + 8'(i);
      end
   end
   always @(posedge clk_i) begin
      if (bus_i.wr)
         mem[bus_i.addr] <= bus_i.wdata;
      // Idle data toggles, so a stale byte reads back inverted on every odd idle cycle
      if (bus_i.rd)
         rdata_o <= mem[bus_i.addr];
      else
         rdata_o <= ~rdata_o;
   end
endmodule
`default_nettype wire
